// file: src/nscr_pkg.sv
// constants for the network setup configuration registers
package nscr_pkg;
  // register port offsets
  localparam logic [2:0] CFG_OFFSET   = 3'h6;
  localparam logic [2:0] SETUP_OFFSET = 3'h7;

  // sub-address codes in config bits 1:0
  localparam logic [1:0] SEL_SETUP1 = 2'h2;
  localparam logic [1:0] SEL_SETUP2 = 2'h3;
  localparam int         SEL_LSB    = 0;

  // first setup register layout
  localparam int         S1_HALF_ARB_BIT = 0;
  localparam int         S1_PRESC_LSB    = 1;
  localparam int         S1_PROMISC_BIT = 4;
  localparam logic [7:0] S1_MASK        = 8'hdf;
  localparam logic [7:0] S1_RESET       = 8'h06;

  // second setup register layout
  localparam int         S2_RCFG_LSB  = 0;
  localparam int         S2_IDLE_OFF_BIT = 2;
  localparam int         S2_ENH_BIT      = 3;
  localparam int         S2_FASTRD_BIT = 7;
  localparam logic [7:0] S2_MASK      = 8'h8f;
  localparam logic [7:0] S2_RESET     = 8'h00;
  localparam logic [7:0] CFG_RESET    = 8'h00;

  // data rate: crystal / (8 * 2^prescaler)
  localparam int CLK_MHZ       = 100;
  localparam int CRYSTAL_MHZ   = 20;
  localparam int XTAL_DIV_BASE = 8;
  localparam int RATE_BASE_CYC = CLK_MHZ * XTAL_DIV_BASE / CRYSTAL_MHZ;
  localparam int RATE_CNT_W    = 13;

  // reconfiguration timeouts at the reference rate, in ms
  localparam longint REF_RATE_BPS  = 312500;
  localparam longint RCFG_TMO_MS_0 = 6720;
  localparam longint RCFG_TMO_MS_1 = 1680;
  localparam longint RCFG_TMO_MS_2 = 840;
  localparam longint RCFG_TMO_MS_3 = 420;
  localparam int     RCFG_W        = 22;
  localparam logic [RCFG_W-1:0] RCFG_TICKS_0 = RCFG_W'(RCFG_TMO_MS_0 * REF_RATE_BPS / 1000);
  localparam logic [RCFG_W-1:0] RCFG_TICKS_1 = RCFG_W'(RCFG_TMO_MS_1 * REF_RATE_BPS / 1000);
  localparam logic [RCFG_W-1:0] RCFG_TICKS_2 = RCFG_W'(RCFG_TMO_MS_2 * REF_RATE_BPS / 1000);
  localparam logic [RCFG_W-1:0] RCFG_TICKS_3 = RCFG_W'(RCFG_TMO_MS_3 * REF_RATE_BPS / 1000);
endpackage

// file: src/nscr_timer_if.sv
// link between the setup registers and the reconfiguration timer
`timescale 1ns/1ps
interface nscr_timer_if;
  import nscr_pkg::*;
  logic              tick;
  logic              restart;
  logic [RCFG_W-1:0] limit;
  logic              expired;
  modport ctrl  (output tick, output restart, output limit, input expired);
  modport timer (input tick, input restart, input limit, output expired);
endinterface

// file: src/nscr_reconfig_timer.sv
// reconfiguration timer counting network bit times
`timescale 1ns/1ps
module nscr_reconfig_timer
  import nscr_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_n,
  nscr_timer_if.timer tmr
);
  logic [RCFG_W-1:0] count_ff;
  logic [RCFG_W-1:0] nxt_count;
  logic              expired_ff;
  logic              nxt_expired;

  // counted in bit ticks so the period follows the data rate
  always_comb begin
    nxt_count   = count_ff;
    nxt_expired = 1'b0;
    if (tmr.restart) begin
      nxt_count = '0;
    end else if (tmr.tick) begin
      if (count_ff >= tmr.limit - RCFG_W'(1)) begin
        nxt_count   = '0;
        nxt_expired = 1'b1;
      end else begin
        nxt_count = count_ff + RCFG_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff   <= '0;
      expired_ff <= 1'b0;
    end else begin
      count_ff   <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end

  assign tmr.expired = expired_ff;

  chk_timeout_at_limit: assert property (@(posedge clock) disable iff (!rst_n)
    expired_ff |-> $past(tmr.tick) && !$past(tmr.restart)
                   && $past(count_ff) >= $past(tmr.limit) - RCFG_W'(1))
    else $error("timeout fired before limit");
endmodule

// file: src/nscr_config_regs.sv
// setup configuration registers of the token network controller
`timescale 1ns/1ps
module nscr_config_regs
  import nscr_pkg::*;
#(
  parameter logic [RCFG_W-1:0] RCFG_TICKS_CODE0 = RCFG_TICKS_0,
  parameter logic [RCFG_W-1:0] RCFG_TICKS_CODE1 = RCFG_TICKS_1,
  parameter logic [RCFG_W-1:0] RCFG_TICKS_CODE2 = RCFG_TICKS_2,
  parameter logic [RCFG_W-1:0] RCFG_TICKS_CODE3 = RCFG_TICKS_3
)
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_ff,
  input  wire logic [7:0] node_id,
  input  wire logic       pkt_valid,
  input  wire logic [7:0] pkt_dest_id,
  input  wire logic       fast_read_strap_pin,
  input  wire logic       bus_muxed,
  input  wire logic       ram_init_req,
  input  wire logic       line_idle,
  input  wire logic       reconfig_restart,
  output logic            pkt_accept_ff,
  output logic            pkt_ack_ff,
  output logic            rate_tick_ff,
  output logic            arb_enable_ff,
  output logic            fast_read_cycle_ff,
  output logic            enhanced_behaviour_ff,
  output logic            ram_init_write_ff,
  output logic            reconfig_timeout_ff
);
  logic [7:0]            cfg_ff;
  logic [7:0]            setup1_ff;
  logic [7:0]            setup2_ff;
  logic [7:0]            nxt_cfg;
  logic [7:0]            nxt_setup1;
  logic [7:0]            nxt_setup2;
  logic [7:0]            nxt_rdata;
  logic [RATE_CNT_W-1:0] rate_cnt_ff;
  logic [RATE_CNT_W-1:0] nxt_rate_cnt;
  logic                  nxt_rate_tick;
  logic                  arb_phase_ff;
  logic                  nxt_arb_phase;
  logic                  nxt_arb_enable;
  logic                  nxt_accept;
  logic                  nxt_ack;
  logic                  nxt_fast_read;
  logic                  nxt_init_write;
  logic [1:0]            setup_register_select;
  logic                  promiscuous_receive;
  logic [2:0]            rate_prescaler;
  logic                  half_speed_arbitration;
  logic                  fast_cpu_read_enable;
  logic                  line_idle_wait_disable;
  logic [1:0]            reconfig_timeout_select;

  nscr_timer_if tmr_if ();

  function automatic logic [RATE_CNT_W-1:0] rate_period(input logic [2:0] presc);
    rate_period = RATE_CNT_W'(RATE_BASE_CYC) << presc;
  endfunction

  function automatic logic [RCFG_W-1:0] rcfg_limit(input logic [1:0] code);
    unique case (code)
      2'h0: rcfg_limit = RCFG_TICKS_CODE0;
      2'h1: rcfg_limit = RCFG_TICKS_CODE1;
      2'h2: rcfg_limit = RCFG_TICKS_CODE2;
      2'h3: rcfg_limit = RCFG_TICKS_CODE3;
    endcase
  endfunction

  assign setup_register_select   = cfg_ff[SEL_LSB +: 2];
  assign promiscuous_receive     = setup1_ff[S1_PROMISC_BIT];
  assign rate_prescaler          = setup1_ff[S1_PRESC_LSB +: 3];
  assign half_speed_arbitration  = setup1_ff[S1_HALF_ARB_BIT];
  assign fast_cpu_read_enable    = setup2_ff[S2_FASTRD_BIT];
  assign line_idle_wait_disable  = setup2_ff[S2_IDLE_OFF_BIT];
  assign reconfig_timeout_select = setup2_ff[S2_RCFG_LSB +: 2];

  // register port: writes and registered read data
  always_comb begin
    nxt_cfg    = cfg_ff;
    nxt_setup1 = setup1_ff;
    nxt_setup2 = setup2_ff;
    nxt_rdata  = reg_rdata_ff;
    if (reg_wr && reg_addr == CFG_OFFSET) begin
      nxt_cfg = reg_wdata;
    end
    if (reg_wr && reg_addr == SETUP_OFFSET) begin
      if (setup_register_select == SEL_SETUP1) begin
        nxt_setup1 = reg_wdata & S1_MASK;
      end else if (setup_register_select == SEL_SETUP2) begin
        nxt_setup2 = reg_wdata & S2_MASK;
      end
    end
    if (reg_rd) begin
      nxt_rdata = 8'h00;
      if (reg_addr == CFG_OFFSET) begin
        nxt_rdata = cfg_ff;
      end else if (reg_addr == SETUP_OFFSET) begin
        if (setup_register_select == SEL_SETUP1) begin
          nxt_rdata = setup1_ff;
        end else if (setup_register_select == SEL_SETUP2) begin
          nxt_rdata = setup2_ff;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff       <= CFG_RESET;
      setup1_ff    <= S1_RESET;
      setup2_ff    <= S2_RESET;
      reg_rdata_ff <= 8'h00;
    end else begin
      cfg_ff       <= nxt_cfg;
      setup1_ff    <= nxt_setup1;
      setup2_ff    <= nxt_setup2;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // bit-rate and arbitration clocks, packet filter, host read speed, ram init
  always_comb begin
    nxt_rate_cnt  = rate_cnt_ff + RATE_CNT_W'(1);
    nxt_rate_tick = 1'b0;
    if (rate_cnt_ff >= rate_period(rate_prescaler) - RATE_CNT_W'(1)) begin
      nxt_rate_cnt  = '0;
      nxt_rate_tick = 1'b1;
    end
    nxt_arb_phase  = half_speed_arbitration ? !arb_phase_ff : 1'b0;
    nxt_arb_enable = !half_speed_arbitration || arb_phase_ff;
    nxt_accept = pkt_valid && (promiscuous_receive || pkt_dest_id == node_id
                               || pkt_dest_id == 8'h00);
    nxt_ack    = pkt_valid && pkt_dest_id == node_id;
    nxt_fast_read = reg_rd && fast_read_strap_pin && fast_cpu_read_enable
                    && !bus_muxed;
    nxt_init_write = ram_init_req && (line_idle || line_idle_wait_disable);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt_ff        <= '0;
      rate_tick_ff       <= 1'b0;
      arb_phase_ff       <= 1'b0;
      arb_enable_ff      <= 1'b0;
      pkt_accept_ff      <= 1'b0;
      pkt_ack_ff         <= 1'b0;
      fast_read_cycle_ff <= 1'b0;
      ram_init_write_ff  <= 1'b0;
    end else begin
      rate_cnt_ff        <= nxt_rate_cnt;
      rate_tick_ff       <= nxt_rate_tick;
      arb_phase_ff       <= nxt_arb_phase;
      arb_enable_ff      <= nxt_arb_enable;
      pkt_accept_ff      <= nxt_accept;
      pkt_ack_ff         <= nxt_ack;
      fast_read_cycle_ff <= nxt_fast_read;
      ram_init_write_ff  <= nxt_init_write;
    end
  end

  // legacy timing while low, enhanced while high
  assign enhanced_behaviour_ff = setup2_ff[S2_ENH_BIT];

  assign tmr_if.tick    = rate_tick_ff;
  assign tmr_if.restart = reconfig_restart;
  assign tmr_if.limit   = rcfg_limit(reconfig_timeout_select);
  assign reconfig_timeout_ff = tmr_if.expired;

  nscr_reconfig_timer u_timer (
    .clock (clock),
    .rst_n (rst_n),
    .tmr   (tmr_if.timer)
  );

  // helper: cycles between bit ticks, ignoring the period after reset or any change of setup1_ff
  logic [RATE_CNT_W-1:0] gap_ff;
  logic [RATE_CNT_W-1:0] nxt_gap;
  logic                  presc_dirty_ff;
  logic                  nxt_presc_dirty;

  always_comb begin
    nxt_gap         = rate_tick_ff ? RATE_CNT_W'(1) : gap_ff + RATE_CNT_W'(1);
    nxt_presc_dirty = (nxt_setup1 != setup1_ff) || (presc_dirty_ff && !rate_tick_ff);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff         <= '0;
      presc_dirty_ff <= 1'b1;
    end else begin
      gap_ff         <= nxt_gap;
      presc_dirty_ff <= nxt_presc_dirty;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_promisc_accept: assert property (
    pkt_valid && promiscuous_receive |=> pkt_accept_ff)
    else $error("promiscuous packet not accepted");

  chk_ack_own_only: assert property (
    pkt_ack_ff |-> $past(pkt_dest_id) == $past(node_id) && $past(pkt_valid))
    else $error("ack for foreign destination");

  chk_rate_period: assert property (
    rate_tick_ff && !presc_dirty_ff |-> gap_ff == rate_period(rate_prescaler))
    else $error("bit tick spacing wrong");

  chk_arb_halving: assert property (
    half_speed_arbitration [*3] |-> arb_enable_ff != $past(arb_enable_ff))
    else $error("arbitration enable not halved");

  chk_arb_full: assert property (
    !half_speed_arbitration [*2] |=> arb_enable_ff)
    else $error("arbitration enable dropped at full speed");

  chk_fast_read_cause: assert property (
    fast_read_cycle_ff |-> $past(fast_read_strap_pin) && $past(fast_cpu_read_enable))
    else $error("fast read without strap and enable");

  chk_write_not_fast: assert property (
    (reg_wr && !reg_rd) || bus_muxed |=> !fast_read_cycle_ff)
    else $error("fast read on write or muxed bus");

  chk_ef_follows_write: assert property (
    reg_wr && reg_addr == SETUP_OFFSET && setup_register_select == SEL_SETUP2
    |=> enhanced_behaviour_ff == $past(reg_wdata[S2_ENH_BIT]))
    else $error("enhanced bit not written");

  chk_init_idle_wait: assert property (
    ram_init_write_ff |-> $past(line_idle) || $past(line_idle_wait_disable))
    else $error("ram init written on busy line");

  chk_init_no_wait: assert property (
    ram_init_req && line_idle_wait_disable |=> ram_init_write_ff)
    else $error("ram init waited despite disable");

  chk_select_read: assert property (
    reg_rd && reg_addr == SETUP_OFFSET && setup_register_select == SEL_SETUP1
    && !reg_wr |=> reg_rdata_ff == $past(setup1_ff))
    else $error("setup read ignored sub-address");

  chk_foreign_refused: assert property (
    pkt_valid && !promiscuous_receive && pkt_dest_id != node_id && pkt_dest_id != 8'h00
    |=> !pkt_accept_ff)
    else $error("foreign packet accepted");

  chk_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata_ff))
    else $error("read data changed without a read");

  cov_promisc_foreign: cover property (
    pkt_accept_ff && !pkt_ack_ff ##1 pkt_accept_ff);
  cov_fast_read: cover property (fast_read_cycle_ff);
  cov_init_busy_line: cover property (ram_init_req && !line_idle && line_idle_wait_disable);
  cov_timeout: cover property (reconfig_timeout_ff);
endmodule

// file: bench/nscr_host_model.sv
// host controller model driving the parallel register port
`timescale 1ns/1ps
module nscr_host_model
  import nscr_pkg::*;
(
  input  wire logic       clock,
  output logic      [2:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata_ff
);
  initial begin
    reg_addr  = 3'h0;
    reg_wdata = 8'h5a;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // callers keep reserved bits zero
  // enhanced bit left to callers, rate never above 5Mbps here
  // shortest timeout only used with a node 255 assumed present
  task automatic write(input logic [2:0] addr, input logic [7:0] data);
    @(posedge clock);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_wdata <= ~data;
  endtask

  task automatic read(input logic [2:0] addr, output logic [7:0] data);
    @(posedge clock);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 data = reg_rdata_ff;
  endtask
endmodule

// file: bench/tb_network_setup_config_regs.sv
// self-checking bench for the setup configuration registers
`timescale 1ns/1ps
module tb_network_setup_config_regs;
  import nscr_pkg::*;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_ff, node_id = 8'h05, pkt_dest_id = 8'h00;
  logic       reg_wr, reg_rd, pkt_valid = 1'b0, strap = 1'b0, bus_muxed = 1'b0;
  logic       ram_init_req = 1'b0, line_idle = 1'b0, restart = 1'b0;
  logic       acc, ack, tick, arb, fast, enh, rinit, tmo;
  int         failures = 0;
  int         checks = 0;
  logic [7:0] d;

  always #5 clock = ~clock;

  nscr_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));

  nscr_config_regs #(.RCFG_TICKS_CODE0(22'h8), .RCFG_TICKS_CODE1(22'h6),
    .RCFG_TICKS_CODE2(22'h4), .RCFG_TICKS_CODE3(22'h3)) uut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .node_id(node_id),
    .pkt_valid(pkt_valid), .pkt_dest_id(pkt_dest_id), .fast_read_strap_pin(strap),
    .bus_muxed(bus_muxed), .ram_init_req(ram_init_req), .line_idle(line_idle),
    .reconfig_restart(restart), .pkt_accept_ff(acc), .pkt_ack_ff(ack),
    .rate_tick_ff(tick), .arb_enable_ff(arb), .fast_read_cycle_ff(fast),
    .enhanced_behaviour_ff(enh), .ram_init_write_ff(rinit), .reconfig_timeout_ff(tmo));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic guard(input int used, input int lim);
    if (used >= lim) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, used, lim - 1);
      report_and_stop();
    end
  endtask

  task automatic set_reg(input logic [1:0] sel, input logic [7:0] v);
    host.write(CFG_OFFSET, {6'h00, sel});
    host.write(SETUP_OFFSET, v);
  endtask

  task automatic get_reg(input logic [1:0] sel, output logic [7:0] v);
    host.write(CFG_OFFSET, {6'h00, sel});
    host.read(SETUP_OFFSET, v);
  endtask

  task automatic test_regs();
    host.read(CFG_OFFSET, d);
    cmp(d, 8'h00);
    get_reg(SEL_SETUP1, d);
    cmp(d, 8'h06);
    get_reg(SEL_SETUP2, d);
    cmp(d, 8'h00);
    cmp(enh, 1'b0);
    set_reg(SEL_SETUP1, 8'hdf);
    get_reg(SEL_SETUP1, d);
    cmp(d, 8'hdf);
    set_reg(SEL_SETUP2, 8'h8f);
    get_reg(SEL_SETUP2, d);
    cmp(d, 8'h8f);
    cmp(enh, 1'b1);
    set_reg(2'h0, 8'h11);
    host.read(SETUP_OFFSET, d);
    cmp(d, 8'h00);
    host.read(3'h0, d);
    cmp(d, 8'h00);
    set_reg(SEL_SETUP1, 8'h06);
    set_reg(SEL_SETUP2, 8'h00);
    $display("test regs done");
  endtask

  task automatic pkt(input logic [7:0] dest, input logic e_acc, input logic e_ack);
    @(posedge clock);
    pkt_valid   <= 1'b1;
    pkt_dest_id <= dest;
    @(posedge clock);
    pkt_valid   <= 1'b0;
    #1;
    cmp({acc, ack}, {e_acc, e_ack});
  endtask

  task automatic test_filter();
    pkt(8'h05, 1'b1, 1'b1);
    pkt(8'h09, 1'b0, 1'b0);
    set_reg(SEL_SETUP1, 8'h16);
    pkt(8'h09, 1'b1, 1'b0);
    pkt(8'h05, 1'b1, 1'b1);
    set_reg(SEL_SETUP1, 8'h06);
    node_id <= 8'h09;
    pkt(8'h09, 1'b1, 1'b1);
    pkt(8'h05, 1'b0, 1'b0);
    node_id <= 8'h05;
    $display("test filter done");
  endtask

  task automatic arb_count(input logic [7:0] s1, input int exp);
    int n;
    set_reg(SEL_SETUP1, s1);
    n = 0;
    repeat (10) begin
      @(posedge clock);
      if (arb === 1'b1) n++;
    end
    cmp(n, exp);
  endtask

  task automatic tick_gap(output int n);
    int i;
    for (i = 0; i < 2000 && tick !== 1'b1; i++) @(posedge clock);
    guard(i, 2000);
    @(posedge clock);
    for (n = 1; n < 2000 && tick !== 1'b1; n++) @(posedge clock);
    guard(n, 2000);
  endtask

  task automatic test_timing();
    int n;
    arb_count(8'h06, 10);
    arb_count(8'h07, 5);
    set_reg(SEL_SETUP1, 8'h06);
    tick_gap(n);
    tick_gap(n);
    cmp(n, 320);
    set_reg(SEL_SETUP1, 8'h08);
    tick_gap(n);
    tick_gap(n);
    cmp(n, 640);
    set_reg(SEL_SETUP1, 8'h06);
    $display("test timing done");
  endtask

  task automatic test_fast_read();
    logic [2:0] cs [4] = '{3'b100, 3'b000, 3'b101, 3'b001};
    logic       ex [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    set_reg(SEL_SETUP2, 8'h80);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      strap     <= cs[k][2];
      bus_muxed <= cs[k][0];
      host.read(SETUP_OFFSET, d);
      cmp(fast, ex[k]);
    end
    strap <= 1'b1;
    bus_muxed <= 1'b0;
    set_reg(SEL_SETUP2, 8'h00);
    host.read(SETUP_OFFSET, d);
    cmp(fast, 1'b0);
    set_reg(SEL_SETUP2, 8'h80);
    #1 cmp(fast, 1'b0);
    $display("test fast read done");
  endtask

  task automatic test_ram_init();
    set_reg(SEL_SETUP2, 8'h00);
    @(posedge clock);
    ram_init_req <= 1'b1;
    line_idle    <= 1'b0;
    repeat (2) @(posedge clock);
    #1 cmp(rinit, 1'b0);
    line_idle <= 1'b1;
    repeat (2) @(posedge clock);
    #1 cmp(rinit, 1'b1);
    line_idle <= 1'b0;
    set_reg(SEL_SETUP2, 8'h04);
    repeat (2) @(posedge clock);
    #1 cmp(rinit, 1'b1);
    ram_init_req <= 1'b0;
    $display("test ram init done");
  endtask

  task automatic test_timeout();
    int lim [4] = '{8, 6, 4, 3};
    int ticks, i;
    logic fired;
    for (int c = 0; c < 4; c++) begin
      set_reg(SEL_SETUP2, {6'h00, 2'(c)});
      for (i = 0; i < 2000 && tick !== 1'b1; i++) @(posedge clock);
      guard(i, 2000);
      restart <= 1'b1;
      @(posedge clock);
      restart <= 1'b0;
      @(posedge clock);
      ticks = 0;
      fired = 1'b0;
      for (i = 0; i < 20000 && !fired; i++) begin
        @(posedge clock);
        if (tick === 1'b1) ticks++;
        if (tmo === 1'b1) fired = 1'b1;
      end
      if (!fired) guard(i, 20000);
      cmp(ticks, lim[c]);
    end
    $display("test timeout done");
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    test_regs();
    test_filter();
    test_timing();
    test_fast_read();
    test_ram_init();
    test_timeout();
    report_and_stop();
  end
endmodule
